// file: core/acq_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef ACQ_REGS_SVH
`define ACQ_REGS_SVH

`define ADDR_W 3
`define IDX_RES_LOW 3'h0
`define IDX_RES_HIGH 3'h1
`define IDX_CFG0 3'h2
`define IDX_CFG1 3'h3
`define IDX_CFG2 3'h4
`define IDX_CFG3 3'h5
`define IDX_CFG4 3'h6
`define IDX_CFG5 3'h7

`define CFG0_START_BIT 7
`define CFG0_NEL_MSB 6
`define CFG0_NEL_LSB 5
`define CFG0_OSR_MSB 4
`define CFG0_OSR_LSB 2
`define CFG0_CONT_BIT 1
`define CFG5_BUSY_BIT 7
`define CFG5_DEF_BIT 6

`define CFG0_RST 8'h28
`define CFG1_RST 8'hF0
`define CFG2_RST 8'hC0
`define CFG3_RST 8'h0C
`define CFG4_RST 8'h00
`define CFG5_RST 8'h00

`define CFG0_WMASK 8'h7E
`define CFG4_WMASK 8'h7F
`define CFG5_WMASK 8'h3F

`define CLK_FREQ_HZ 32'h05F5_E100
`define OSC_FREQ_HZ 32'h003D_0900
`define OSC_DIV (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define FS_FAST_DIV 8'h08
`define OSR_BASE 11'h008
`define SCALE_BASE 4'hC

`endif

// file: core/acq_pkg.sv
// Types shared by the acquisition control modules
package acq_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_RUN = 2'b10
	} seq_state_t;
	typedef logic [7:0] reg_byte_t;
	typedef logic signed [15:0] result_t;
	typedef logic signed [14:0] accum_t;
endpackage : acq_pkg

// file: core/conv_if.sv
// Link between register bank and conversion sequencer
`timescale 1ns/1ns
`default_nettype none
interface conv_if;
	import acq_pkg::*;
	logic start;
	logic busy;
	logic done;
	result_t result;
	logic [1:0] nel;
	logic [2:0] osr;
	logic [1:0] fs;
	modport ctrl(output start, nel, osr, fs, input busy, done, result);
	modport seq(input start, nel, osr, fs, output busy, done, result);
endinterface : conv_if
`default_nettype wire

// file: core/conv_sequencer.sv
// Incremental conversion sequencer with chopping and result scaling
`timescale 1ns/1ns
`default_nettype none
`include "acq_regs.svh"
module conv_sequencer
	import acq_pkg::*;
#(
	parameter int OSC_DIV = `OSC_DIV
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	conv_if.seq cv,
	input wire logic i_mod_bit,
	output logic o_chop,
	output logic o_sample_tick
);
	seq_state_t state_ff;
	logic [5:0] osc_cnt_ff;
	logic [7:0] fs_cnt_ff;
	logic [9:0] samp_cnt_ff;
	logic [2:0] elem_cnt_ff;
	accum_t acc_ff;
	accum_t nxt_acc;
	logic chop_ff;
	logic [1:0] nel_ff;
	logic [2:0] osr_ff;
	logic [1:0] fs_ff;
	logic done_ff;
	result_t result_ff;
	logic osc_tick;
	logic fs_tick;

	function automatic logic [9:0] osr_last(input logic [2:0] osr);
		logic [10:0] n;
		n = `OSR_BASE << osr;
		return 10'(n - 11'h001);
	endfunction : osr_last

	function automatic logic [7:0] fs_last(input logic [1:0] fs);
		logic [7:0] n;
		n = `FS_FAST_DIV << (2'h3 - fs);
		return n - 8'h01;
	endfunction : fs_last

	// Full-scale code is half of the 16-bit span; top end saturates
	function automatic result_t scale_acc(input accum_t a,
		input logic [1:0] nel, input logic [2:0] osr);
		logic [3:0] sh;
		logic signed [17:0] w;
		sh = `SCALE_BASE - {2'h0, nel} - {1'h0, osr};
		w = 18'(a) <<< sh;
		if (w > 18'sh0_7FFF)
			return 16'sh7FFF;
		return w[15:0];
	endfunction : scale_acc

	// Oscillator-rate tick from the reference clock
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			osc_cnt_ff <= 6'h00;
		else if (osc_cnt_ff == 6'(OSC_DIV - 1))
			osc_cnt_ff <= 6'h00;
		else
			osc_cnt_ff <= osc_cnt_ff + 6'h01;
	end
	assign osc_tick = (osc_cnt_ff == 6'(OSC_DIV - 1));
	assign fs_tick = osc_tick && (fs_cnt_ff == fs_last(fs_ff));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			fs_cnt_ff <= 8'h00;
		else if (cv.start || fs_tick)
			fs_cnt_ff <= 8'h00;
		else if (osc_tick)
			fs_cnt_ff <= fs_cnt_ff + 8'h01;
	end

	// Chopping flips the input sign, so the sample is flipped back here
	assign nxt_acc = (i_mod_bit ^ chop_ff) ? acc_ff + 15'sh0001
		: acc_ff - 15'sh0001;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= SEQ_IDLE;
			samp_cnt_ff <= 10'h000;
			elem_cnt_ff <= 3'h0;
			acc_ff <= 15'sh0000;
			chop_ff <= 1'b0;
			nel_ff <= 2'h0;
			osr_ff <= 3'h0;
			fs_ff <= 2'h3;
			done_ff <= 1'b0;
			result_ff <= 16'sh0000;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
			SEQ_IDLE, SEQ_RUN: begin
				if (cv.start) begin
					// A start while running restarts cleanly
					state_ff <= SEQ_RUN;
					samp_cnt_ff <= 10'h000;
					elem_cnt_ff <= 3'h0;
					acc_ff <= 15'sh0000;
					chop_ff <= 1'b0;
					nel_ff <= cv.nel;
					osr_ff <= cv.osr;
					fs_ff <= cv.fs;
				end else if (state_ff == SEQ_RUN && fs_tick) begin
					acc_ff <= nxt_acc;
					if (samp_cnt_ff != osr_last(osr_ff)) begin
						samp_cnt_ff <= samp_cnt_ff + 10'h001;
					end else if (elem_cnt_ff !=
						3'((4'h1 << nel_ff) - 4'h1)) begin
						samp_cnt_ff <= 10'h000;
						elem_cnt_ff <= elem_cnt_ff + 3'h1;
						chop_ff <= ~chop_ff;
					end else begin
						state_ff <= SEQ_IDLE;
						done_ff <= 1'b1;
						result_ff <= scale_acc(nxt_acc, nel_ff, osr_ff);
					end
				end
			end
			default: begin
				state_ff <= SEQ_IDLE;
			end
			endcase
		end
	end

	assign cv.busy = (state_ff == SEQ_RUN);
	assign cv.done = done_ff;
	assign cv.result = result_ff;
	assign o_chop = chop_ff;
	assign o_sample_tick = fs_tick && (state_ff == SEQ_RUN);
endmodule : conv_sequencer
`default_nettype wire

// file: core/acquisition_chain_control.sv
// Register bank and control for the acquisition chain
// What this block does
// - Modulator powered only when enable bit 0 set
// - Enable bits 1..3 power gain stages one..three
// - Disabled gain stage is bypassed through
// - Eight 8-bit registers: six config, two result
// - Read-only 16-bit result, low and high byte
// - Result coded in two's complement
// - Start bit runs one conversion, queued if busy
// - Start bit always reads zero
// - Resolution programmable from 3 to 13 bits
// - All chain timing from 4 MHz oscillator
// - Registers reached only through the control port
// - Offset control only on stages two and three
// - Single-ended mode ties one leg to common
// - Continuous bit restarts after each conversion
// - Busy bit high while a conversion runs
// - Defaults write reloads config and restarts now
// - Two-power elementary conversions, input chopped between
`timescale 1ns/1ns
`default_nettype none
`include "acq_regs.svh"
module acquisition_chain_control
	import acq_pkg::*;
#(
	parameter int OSC_DIV = `OSC_DIV
) (
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic [2:0] I_REG_ADDR,
	input wire logic I_REG_WR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic I_REG_RD,
	output logic [7:0] O_REG_RDATA,
	input wire logic I_MOD_BIT,
	output logic O_MOD_EN,
	output logic [2:0] O_STAGE_EN,
	output logic [2:0] O_STAGE_BYPASS,
	output logic [1:0] O_MOD_BIAS,
	output logic [1:0] O_STAGE_BIAS,
	output logic [1:0] O_SAMPLE_FREQ,
	output logic O_COARSE_GAIN,
	output logic [1:0] O_MID_GAIN,
	output logic [3:0] O_MID_OFFSET,
	output logic [6:0] O_FINE_GAIN,
	output logic [6:0] O_FINE_OFFSET,
	output logic O_INPUT_SINGLE,
	output logic O_INPUT_CROSS,
	output logic [2:0] O_INPUT_CHAN,
	output logic O_NEG_LEG_COMMON,
	output logic O_REF_SEL,
	output logic O_CHOP,
	output logic O_SAMPLE_TICK,
	output logic O_BUSY
);
	conv_if cv();
	reg_byte_t cfg_ff [0:5];
	result_t result_ff;
	logic pending_ff;
	logic wr_cfg;
	logic [2:0] cfg_idx;
	logic start_wr;
	logic cont_rise;
	logic def_wr;
	logic issue;
	logic busy_any;
	reg_byte_t cfg0_src;
	reg_byte_t cfg2_src;
	integer i;

	function automatic reg_byte_t cfg_default(input logic [2:0] idx);
		case (idx)
		3'h0: return `CFG0_RST;
		3'h1: return `CFG1_RST;
		3'h2: return `CFG2_RST;
		3'h3: return `CFG3_RST;
		3'h4: return `CFG4_RST;
		3'h5: return `CFG5_RST;
		default: return 8'h00;
		endcase
	endfunction : cfg_default

	// Strobe-only and reserved bits never store
	function automatic reg_byte_t cfg_wmask(input logic [2:0] idx);
		case (idx)
		3'h0: return `CFG0_WMASK;
		3'h4: return `CFG4_WMASK;
		3'h5: return `CFG5_WMASK;
		default: return 8'hFF;
		endcase
	endfunction : cfg_wmask

	assign wr_cfg = I_REG_WR && (I_REG_ADDR >= `IDX_CFG0);
	assign cfg_idx = I_REG_ADDR - `IDX_CFG0;
	assign start_wr = I_REG_WR && (I_REG_ADDR == `IDX_CFG0)
		&& I_REG_WDATA[`CFG0_START_BIT];
	assign cont_rise = I_REG_WR && (I_REG_ADDR == `IDX_CFG0)
		&& I_REG_WDATA[`CFG0_CONT_BIT]
		&& !cfg_ff[0][`CFG0_CONT_BIT];
	assign def_wr = I_REG_WR && (I_REG_ADDR == `IDX_CFG5)
		&& I_REG_WDATA[`CFG5_DEF_BIT];

	// Configuration bank; a defaults write overrides the written data
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			for (i = 0; i < 6; i = i + 1)
				cfg_ff[i] <= cfg_default(3'(i));
		end else if (def_wr) begin
			for (i = 0; i < 6; i = i + 1)
				cfg_ff[i] <= cfg_default(3'(i));
		end else if (wr_cfg) begin
			cfg_ff[cfg_idx] <= I_REG_WDATA & cfg_wmask(cfg_idx);
		end
	end

	// Queued request; a new request in the issue cycle is kept
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N)
			pending_ff <= 1'b0;
		else if (def_wr)
			pending_ff <= 1'b0;
		else if (start_wr || cont_rise ||
			(cv.done && cfg_ff[0][`CFG0_CONT_BIT]))
			pending_ff <= 1'b1;
		else if (issue)
			pending_ff <= 1'b0;
	end

	assign issue = def_wr || (pending_ff && !cv.busy);
	assign busy_any = cv.busy || pending_ff;
	assign cv.start = issue;
	// A defaults restart runs with the default settings, not the old ones
	assign cfg0_src = def_wr ? `CFG0_RST : cfg_ff[0];
	assign cfg2_src = def_wr ? `CFG2_RST : cfg_ff[2];
	assign cv.nel = cfg0_src[`CFG0_NEL_MSB:`CFG0_NEL_LSB];
	assign cv.osr = cfg0_src[`CFG0_OSR_MSB:`CFG0_OSR_LSB];
	assign cv.fs = cfg2_src[7:6];

	// Both bytes load in one edge from a finished conversion
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N)
			result_ff <= 16'sh0000;
		else if (cv.done)
			result_ff <= cv.result;
	end

	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_REG_RDATA <= 8'h00;
		end else if (I_REG_RD) begin
			case (I_REG_ADDR)
			`IDX_RES_LOW: O_REG_RDATA <= result_ff[7:0];
			`IDX_RES_HIGH: O_REG_RDATA <= result_ff[15:8];
			`IDX_CFG5: O_REG_RDATA <= {busy_any, cfg_ff[5][6:0]};
			default: O_REG_RDATA <= cfg_ff[cfg_idx];
			endcase
		end
	end

	conv_sequencer #(
		.OSC_DIV(OSC_DIV)
	) u_seq (
		.i_clk(I_REF_CLK),
		.i_rst_n(I_ARST_N),
		.cv(cv),
		.i_mod_bit(I_MOD_BIT),
		.o_chop(O_CHOP),
		.o_sample_tick(O_SAMPLE_TICK)
	);

	assign O_MOD_EN = cfg_ff[1][0];
	assign O_STAGE_EN = cfg_ff[1][3:1];
	assign O_STAGE_BYPASS = ~cfg_ff[1][3:1];
	assign O_MOD_BIAS = cfg_ff[1][7:6];
	assign O_STAGE_BIAS = cfg_ff[1][5:4];
	assign O_SAMPLE_FREQ = cfg_ff[2][7:6];
	assign O_COARSE_GAIN = cfg_ff[3][7];
	assign O_MID_GAIN = cfg_ff[2][5:4];
	assign O_MID_OFFSET = cfg_ff[2][3:0];
	assign O_FINE_GAIN = cfg_ff[3][6:0];
	assign O_FINE_OFFSET = cfg_ff[4][6:0];
	assign O_INPUT_SINGLE = cfg_ff[5][5];
	assign O_INPUT_CROSS = cfg_ff[5][4];
	assign O_INPUT_CHAN = cfg_ff[5][3:1];
	assign O_NEG_LEG_COMMON = cfg_ff[5][5];
	assign O_REF_SEL = cfg_ff[5][0];
	assign O_BUSY = busy_any;
endmodule : acquisition_chain_control
`default_nettype wire

// file: tb/acq_ctrl_asserts.sv
// Port-level assertions for the acquisition chain control block
`timescale 1ns/1ns
`default_nettype none
module acq_ctrl_asserts (
	input wire logic I_REF_CLK,
	input wire logic I_ARST_N,
	input wire logic [2:0] I_REG_ADDR,
	input wire logic I_REG_WR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic I_REG_RD,
	input wire logic [7:0] O_REG_RDATA,
	input wire logic O_MOD_EN,
	input wire logic [2:0] O_STAGE_EN,
	input wire logic [2:0] O_STAGE_BYPASS,
	input wire logic [6:0] O_FINE_GAIN,
	input wire logic O_INPUT_SINGLE,
	input wire logic O_NEG_LEG_COMMON,
	input wire logic O_CHOP,
	input wire logic O_SAMPLE_TICK,
	input wire logic O_BUSY
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_ARST_N);
	wire logic wr2 = I_REG_WR && I_REG_ADDR == 3'h2;
	wire logic wr3 = I_REG_WR && I_REG_ADDR == 3'h3;
	chk_mod_enable: assert property (wr3 |=>
		O_MOD_EN == $past(I_REG_WDATA[0]))
		else $error("modulator enable wrong");
	chk_stage_enable: assert property (wr3 |=>
		O_STAGE_EN == $past(I_REG_WDATA[3:1]))
		else $error("stage enable wrong");
	chk_bypass_inverse: assert property (
		O_STAGE_BYPASS == ~O_STAGE_EN)
		else $error("bypass not inverse of enable");
	chk_start_reads_zero: assert property (
		I_REG_RD && I_REG_ADDR == 3'h2 |=> !O_REG_RDATA[7])
		else $error("start bit read as one");
	chk_busy_on_start: assert property (
		wr2 && I_REG_WDATA[7] |=> O_BUSY)
		else $error("busy missing after start");
	chk_tick_when_idle: assert property (!O_BUSY |-> !O_SAMPLE_TICK)
		else $error("sample tick while idle");
	// A restart from idle clears the phase, so look at busy after the edge
	chk_chop_in_run: assert property ($changed(O_CHOP) |-> O_BUSY)
		else $error("chop moved while idle");
	chk_defaults_restart: assert property (
		I_REG_WR && I_REG_ADDR == 3'h7 && I_REG_WDATA[6] |=>
		O_BUSY && O_STAGE_EN == 3'h0 && !O_MOD_EN)
		else $error("defaults write not applied");
	chk_fine_gain_wr: assert property (
		I_REG_WR && I_REG_ADDR == 3'h5 |=>
		O_FINE_GAIN == $past(I_REG_WDATA[6:0]))
		else $error("fine gain not stored");
	chk_neg_leg_mode: assert property (
		O_NEG_LEG_COMMON == O_INPUT_SINGLE)
		else $error("negative leg select wrong");
endmodule : acq_ctrl_asserts
bind acquisition_chain_control acq_ctrl_asserts u_chk (.*);
`default_nettype wire

// file: tb/mod_model.sv
// Modulator stand-in that applies the chop flip to one fixed input sign
`timescale 1ns/1ns
`default_nettype none
module mod_model (
	input wire logic i_level,
	input wire logic i_chop,
	output logic o_bit
);
	assign o_bit = i_level ^ i_chop;
endmodule : mod_model
`default_nettype wire

// file: tb/testbench.sv
// Register-level testbench for the acquisition chain control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import acq_pkg::*;
	logic clk, rst_n, wr, rd, level, mbit, men, cg, chop, tick, busy;
	logic isng, icrs, nleg, rsel;
	logic [2:0] addr, sen, byp, ichan;
	logic [1:0] mbias, sbias, sfreq, mgain;
	logic [3:0] moff;
	reg_byte_t wd, rdat;
	logic [6:0] fg, foff;
	int error_cnt = 0, cmp_count = 0, ticks = 0, n, c;
	reg_byte_t rst_v [8] = '{8'h00, 8'h00, 8'h28, 8'hF0, 8'hC0, 8'h0C,
		8'h00, 8'h00};
	acquisition_chain_control #(.OSC_DIV(2)) dut (.I_REF_CLK(clk),
		.I_ARST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WR(wr),
		.I_REG_WDATA(wd), .I_REG_RD(rd), .O_REG_RDATA(rdat),
		.I_MOD_BIT(mbit), .O_MOD_EN(men), .O_STAGE_EN(sen),
		.O_STAGE_BYPASS(byp), .O_MOD_BIAS(mbias), .O_STAGE_BIAS(sbias),
		.O_SAMPLE_FREQ(sfreq), .O_COARSE_GAIN(cg), .O_MID_GAIN(mgain),
		.O_MID_OFFSET(moff), .O_FINE_GAIN(fg), .O_FINE_OFFSET(foff),
		.O_INPUT_SINGLE(isng), .O_INPUT_CROSS(icrs), .O_INPUT_CHAN(ichan),
		.O_NEG_LEG_COMMON(nleg), .O_REF_SEL(rsel), .O_CHOP(chop),
		.O_SAMPLE_TICK(tick), .O_BUSY(busy));
	mod_model u_mod (.i_level(level), .i_chop(chop), .o_bit(mbit));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrr(input logic [2:0] a, input reg_byte_t d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wrr
	task automatic rdc(input logic [2:0] a, input reg_byte_t e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdat, e);
	endtask : rdc
	task automatic idle();
		c = 0;
		while (busy !== 1'b0 && c < 3000) begin
			@(posedge clk);
			#1 c++;
		end
	endtask : idle
	task automatic test_done();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wd = 8'h00;
		level = 1'b1;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rst_v[i]) rdc(3'(i), rst_v[i]);
		chk({mbias, sbias, sfreq, mgain, moff}, 12'hFC0);
		wrr(3'h3, 8'h0F);
		chk({men, sen, byp}, 7'b1111000);
		wrr(3'h3, 8'h0A);
		chk({men, sen, byp}, 7'b0101010);
		wrr(3'h0, 8'hFF);
		wrr(3'h1, 8'hFF);
		rdc(3'h0, 8'h00);
		rdc(3'h1, 8'h00);
		wrr(3'h5, 8'h8C);
		chk({cg, fg}, 8'h8C);
		wrr(3'h6, 8'hFF);
		rdc(3'h6, 8'h7F);
		chk(foff, 7'h7F);
		wrr(3'h7, 8'h14);
		chk({isng, icrs, ichan, nleg, rsel}, 7'h28);
		wrr(3'h7, 8'hBF);
		rdc(3'h7, 8'h3F);
		chk({isng, icrs, ichan, nleg, rsel}, 7'h7F);
		for (int s = 0; s < 2; s++) begin
			level <= (s == 0);
			n = ticks;
			wrr(3'h2, 8'hA0);
			rdc(3'h2, 8'h20);
			rdc(3'h7, 8'hBF);
			idle();
			chk(c > 240 && c < 262, 1);
			chk(ticks - n, 16);
			chk(chop, 1'b1);
			rdc(3'h0, s ? 8'h00 : 8'hFF);
			rdc(3'h1, s ? 8'h80 : 8'h7F);
		end
		n = ticks;
		wrr(3'h2, 8'hA0);
		wrr(3'h2, 8'hA0);
		idle();
		chk(ticks - n, 32);
		wrr(3'h2, 8'h22);
		repeat (600) @(posedge clk);
		#1 chk(busy, 1);
		wrr(3'h2, 8'h20);
		idle();
		chk(c < 300, 1);
		wrr(3'h4, 8'h9A);
		chk({sfreq, mgain, moff}, 8'h9A);
		n = ticks;
		wrr(3'h2, 8'h80);
		idle();
		chk(c > 240 && c < 262, 1);
		chk(ticks - n, 8);
		chk(chop, 1'b0);
		rdc(3'h1, 8'h80);
		wrr(3'h2, 8'hA0);
		wrr(3'h3, 8'h0F);
		wrr(3'h7, 8'h40);
		n = ticks;
		chk(busy, 1);
		chk({mbias, sbias, sfreq}, 6'h3F);
		rdc(3'h3, 8'hF0);
		rdc(3'h2, 8'h28);
		rdc(3'h4, 8'hC0);
		idle();
		chk(c > 1000 && c < 1030, 1);
		chk(c < 3000, 1);
		chk(ticks - n, 64);
		test_done();
	end
endmodule : testbench
`default_nettype wire
